/* hw/canopen_status_led_sequencer.sv */
// Purpose: Bicolour fieldbus status indicator sequencer for a CANopen node.
// Assumes: Condition inputs come from protocol logic on the same clock,
//          so none of them needs a synchroniser.
// Notes:   Outputs are registered; a condition change shows one edge later, the new LED colour two edges later.
//          The error-control event is a held level; no sticky copy is kept here.
//          Phase lengths are exact in cycles, the first phase after a change included.
`timescale 1ns/10ps

module canopen_status_led_sequencer #(
   parameter int CYCLES_PER_MS = led_seq_pkg::CYCLES_PER_MS
) (
   input  wire logic        clk,                 // System clock, 100 MHz
   input  wire logic        rst,                 // Synchronous reset, active high
   input  wire logic        slave_role,          // Node runs the slave stack
   input  wire logic        reset_active,        // Node is executing a reset
   input  wire logic        unconfigured,        // No configuration loaded
   input  wire logic        bus_off,             // Bus controller is bus-off
   input  wire logic        error_control_event, // Guard or heartbeat event seen
   input  wire logic        warning_reached,     // An error counter at warning level
   input  wire logic        autobaud_active,     // Bit-rate detection running
   input  wire logic        operational,         // Network state: running
   input  wire logic        preparing_state,     // Network state: preparing
   input  wire logic        halted_state,        // Network state: halted
   output logic             led_red,             // Red element lit, registered
   output logic             led_green,           // Green element lit, registered
   output logic [2:0]       shown_pattern        // Pattern on display, registered
);

   // ---------------------------------------------------------------
   // Elaboration check
   // ---------------------------------------------------------------
   generate
      // Below two cycles per ms the registered tick cannot keep its period
      if (CYCLES_PER_MS < 2) begin : g_bad_rate
         $error("CYCLES_PER_MS must be at least 2");
      end
      // A zero length would wrap phase_len - 1 and stretch the phase to 1024 ms
      if (led_seq_pkg::BLINK_ON_MS == '0 || led_seq_pkg::BLINK_OFF_MS == '0 ||
          led_seq_pkg::FLICKER_ON_MS == '0 || led_seq_pkg::FLICKER_OFF_MS == '0) begin : g_len_a
         $error("Blink and flicker phases must last at least 1 ms");
      end
      if (led_seq_pkg::FLASH_ON_MS == '0 || led_seq_pkg::FLASH_GAP_MS == '0 ||
          led_seq_pkg::LONG_OFF_MS == '0 || led_seq_pkg::STEADY_MS == '0) begin : g_len_b
         $error("Flash and steady phases must last at least 1 ms");
      end
   endgenerate

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   led_seq_pkg::pattern_type                pattern_ff;
   led_seq_pkg::pattern_type                nxt_pattern;
   logic [led_seq_pkg::PHASE_W-1:0]         phase_ff;
   logic [led_seq_pkg::MS_W-1:0]            ms_cnt_ff;
   logic                                    led_red_ff;
   logic                                    led_green_ff;
   logic                                    pattern_change;
   logic                                    ms_tick;
   // Phase table outputs, decoded from the pattern and phase registers
   logic [led_seq_pkg::MS_W-1:0]            phase_len;
   logic [led_seq_pkg::MS_W-1:0]            phase_end_ms;
   logic                                    phase_last;
   logic                                    phase_red;
   logic                                    phase_green;
   logic                                    phase_done;

   // ---------------------------------------------------------------
   // Millisecond time base
   // ---------------------------------------------------------------
   // Realigned on every pattern change so the first phase is full length; a free
   // running base would cut the first phase short by up to one ms
   ms_tick_gen #(
      .CYCLES_PER_MS (CYCLES_PER_MS)
   ) u_ms_tick (
      .clk     (clk),
      .rst     (rst),
      .restart (pattern_change),
      .tick    (ms_tick)
   );

   // ---------------------------------------------------------------
   // Pattern selection
   // ---------------------------------------------------------------
   // Faults outrank the network state, and autobaud sits below every fault so an
   // error stays visible while the bit rate is still being searched for
   always_comb begin
      if (reset_active || unconfigured) begin
         nxt_pattern = led_seq_pkg::PAT_DARK;
      end else if (bus_off) begin
         nxt_pattern = led_seq_pkg::PAT_RED_ON;
      end else if (error_control_event) begin
         nxt_pattern = led_seq_pkg::PAT_DFLASH_R;
      end else if (warning_reached) begin
         nxt_pattern = led_seq_pkg::PAT_SFLASH_R;
      end else if (slave_role && autobaud_active) begin
         nxt_pattern = led_seq_pkg::PAT_FLICKER;
      end else if (operational) begin
         nxt_pattern = led_seq_pkg::PAT_GREEN_ON;
      end else if (preparing_state) begin
         nxt_pattern = led_seq_pkg::PAT_BLINK_G;
      end else if (halted_state) begin
         nxt_pattern = led_seq_pkg::PAT_SFLASH_G;
      end else begin
         // No known network state: nothing meaningful to show
         nxt_pattern = led_seq_pkg::PAT_DARK;
      end
   end

   assign pattern_change = (nxt_pattern != pattern_ff);

   // ---------------------------------------------------------------
   // Pattern register
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         pattern_ff <= led_seq_pkg::PAT_DARK;
      end else begin
         pattern_ff <= nxt_pattern;
      end
   end

   // ---------------------------------------------------------------
   // Phase table
   // ---------------------------------------------------------------
   // Each phase gives its length in ms, its colours and whether it wraps
   always_comb begin
      phase_len   = led_seq_pkg::STEADY_MS;
      phase_last  = 1'b1;
      phase_red   = 1'b0;
      phase_green = 1'b0;
      case (pattern_ff)
         // Steady patterns: one phase that simply wraps on itself
         led_seq_pkg::PAT_DARK: begin
            phase_len = led_seq_pkg::STEADY_MS;
         end
         led_seq_pkg::PAT_GREEN_ON: begin
            phase_green = 1'b1;
         end
         led_seq_pkg::PAT_RED_ON: begin
            phase_red = 1'b1;
         end

         // Slow blink: equal lit and dark halves
         led_seq_pkg::PAT_BLINK_G: begin
            case (phase_ff)
               2'h0: begin
                  phase_len   = led_seq_pkg::BLINK_ON_MS;
                  phase_green = 1'b1;
                  phase_last  = 1'b0;
               end
               default: begin
                  phase_len   = led_seq_pkg::BLINK_OFF_MS;
               end
            endcase
         end

         // Single flash: one short pulse, then the long dark phase
         led_seq_pkg::PAT_SFLASH_G,
         led_seq_pkg::PAT_SFLASH_R: begin
            case (phase_ff)
               2'h0: begin
                  phase_len   = led_seq_pkg::FLASH_ON_MS;
                  phase_green = (pattern_ff == led_seq_pkg::PAT_SFLASH_G);
                  phase_red   = (pattern_ff == led_seq_pkg::PAT_SFLASH_R);
                  phase_last  = 1'b0;
               end
               default: begin
                  phase_len   = led_seq_pkg::LONG_OFF_MS;
               end
            endcase
         end

         // Double flash: pulse, short gap, pulse, then the long dark phase
         led_seq_pkg::PAT_DFLASH_R: begin
            case (phase_ff)
               2'h0: begin
                  phase_len   = led_seq_pkg::FLASH_ON_MS;
                  phase_red   = 1'b1;
                  phase_last  = 1'b0;
               end
               2'h1: begin
                  phase_len   = led_seq_pkg::FLASH_GAP_MS;
                  phase_last  = 1'b0;
               end
               2'h2: begin
                  phase_len   = led_seq_pkg::FLASH_ON_MS;
                  phase_red   = 1'b1;
                  phase_last  = 1'b0;
               end
               default: begin
                  phase_len   = led_seq_pkg::LONG_OFF_MS;
               end
            endcase
         end

         led_seq_pkg::PAT_FLICKER: begin
            // Red and green take turns so both colours show within 200 ms
            case (phase_ff)
               2'h0: begin
                  phase_len   = led_seq_pkg::FLICKER_ON_MS;
                  phase_red   = 1'b1;
                  phase_last  = 1'b0;
               end
               2'h1: begin
                  phase_len   = led_seq_pkg::FLICKER_OFF_MS;
                  phase_last  = 1'b0;
               end
               2'h2: begin
                  phase_len   = led_seq_pkg::FLICKER_ON_MS;
                  phase_green = 1'b1;
                  phase_last  = 1'b0;
               end
               default: begin
                  phase_len   = led_seq_pkg::FLICKER_OFF_MS;
               end
            endcase
         end

         // Codes outside the table show dark rather than a stale colour
         default: begin
            phase_len   = led_seq_pkg::STEADY_MS;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // Phase sequencing
   // ---------------------------------------------------------------
   // A phase ends on the tick that completes its last ms; the LEDs follow one edge
   // later, matching the one dark edge at a pattern change, so lengths stay exact
   assign phase_end_ms = phase_len - 1'b1;
   assign phase_done   = ms_tick && (ms_cnt_ff == phase_end_ms);

   // Counts whole ms inside the current phase; a change of pattern or the end of
   // the phase clears it, so each phase times itself from zero
   always_ff @(posedge clk) begin
      if (rst || pattern_change) begin
         ms_cnt_ff <= '0;
      end else if (phase_done) begin
         ms_cnt_ff <= '0;
      end else if (ms_tick) begin
         ms_cnt_ff <= ms_cnt_ff + 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // Phase register
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst || pattern_change) begin
         phase_ff <= led_seq_pkg::PHASE_FIRST;
      end else if (phase_done) begin
         if (phase_last) begin
            phase_ff <= led_seq_pkg::PHASE_FIRST;
         end else begin
            phase_ff <= phase_ff + 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // Indicator drive
   // ---------------------------------------------------------------
   // Registered so the pins never glitch while the table decodes; both go dark
   // for one edge on a pattern change so no colour of the old pattern leaks over
   always_ff @(posedge clk) begin
      if (rst || pattern_change) begin
         led_red_ff <= 1'b0;
      end else begin
         led_red_ff <= phase_red;
      end
   end

   always_ff @(posedge clk) begin
      if (rst || pattern_change) begin
         led_green_ff <= 1'b0;
      end else begin
         led_green_ff <= phase_green;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign led_red       = led_red_ff;
   assign led_green     = led_green_ff;
   assign shown_pattern = pattern_ff;

endmodule

/* hw/ms_tick_gen.sv */
// Purpose: Millisecond tick generator for the indicator sequencer.
// Assumes: Free-running system clock; restart comes from same-clock logic.
// Notes:   Tick is a one-cycle registered pulse every CYCLES_PER_MS cycles.
`timescale 1ns/10ps
module ms_tick_gen #(
   parameter int CYCLES_PER_MS = 100000
) (
   input  wire logic clk,      // System clock
   input  wire logic rst,      // Synchronous reset, active high
   input  wire logic restart,  // Realign the time base to this cycle
   output logic      tick      // One-cycle pulse per millisecond
);

   localparam int CNT_W = $clog2(CYCLES_PER_MS);
   localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(CYCLES_PER_MS - 1);
   localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);

   // ---------------------------------------------------------------
   // Elaboration check
   // ---------------------------------------------------------------
   generate
      if (CYCLES_PER_MS < 2) begin : g_bad_rate
         $error("ms_tick_gen needs at least two cycles per tick");
      end
   endgenerate

   logic [CNT_W-1:0] cnt_ff;
   logic             tick_ff;

   // Restart loads one, not zero: the tick is registered, so this puts the first
   // tick a full CYCLES_PER_MS cycles after the restart edge
   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_ff <= '0;
      end else if (restart) begin
         cnt_ff <= CNT_ONE;
      end else if (cnt_ff == CNT_LAST) begin
         cnt_ff <= '0;
      end else begin
         cnt_ff <= cnt_ff + 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst || restart) begin
         tick_ff <= 1'b0;
      end else begin
         tick_ff <= (cnt_ff == CNT_LAST);
      end
   end

   assign tick = tick_ff;

endmodule

/* pkg/led_seq_pkg.sv */
// Purpose: Shared constants and types of the status indicator sequencer.
// Assumes: One 100 MHz system clock; all pattern timing counted in milliseconds.
// Notes:   Durations are in ms; the cycle count per ms is derived from the clock.
package led_seq_pkg;

   // ---------------------------------------------------------------
   // Clock and time base
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS  = 10;
   localparam int MS_IN_NS       = 1000000;
   localparam int CYCLES_PER_MS  = MS_IN_NS / CLK_PERIOD_NS;

   // ---------------------------------------------------------------
   // Pattern phase durations, in ms
   // ---------------------------------------------------------------
   localparam int MS_W           = 10;
   localparam logic [MS_W-1:0] BLINK_ON_MS     = 10'h0C8;
   localparam logic [MS_W-1:0] BLINK_OFF_MS    = 10'h0C8;
   localparam logic [MS_W-1:0] FLASH_ON_MS     = 10'h0C8;
   localparam logic [MS_W-1:0] FLASH_GAP_MS    = 10'h0C8;
   localparam logic [MS_W-1:0] LONG_OFF_MS     = 10'h3E8;
   localparam logic [MS_W-1:0] FLICKER_ON_MS   = 10'h032;
   localparam logic [MS_W-1:0] FLICKER_OFF_MS  = 10'h032;
   // Steady patterns have one phase; its length only paces the idle counter
   localparam logic [MS_W-1:0] STEADY_MS       = 10'h3E8;

   // ---------------------------------------------------------------
   // Phases and patterns
   // ---------------------------------------------------------------
   localparam int PHASE_W = 2;
   localparam logic [PHASE_W-1:0] PHASE_FIRST = 2'h0;

   typedef enum logic [2:0] {
      PAT_DARK      = 3'h0,
      PAT_GREEN_ON  = 3'h1,
      PAT_BLINK_G   = 3'h3,
      PAT_SFLASH_G  = 3'h2,
      PAT_FLICKER   = 3'h6,
      PAT_SFLASH_R  = 3'h7,
      PAT_DFLASH_R  = 3'h5,
      PAT_RED_ON    = 3'h4
   } pattern_type;

endpackage

/* verification/canopen_status_led_sequencer_tb_top.sv */
// Purpose: Directed tests of the status indicator sequencer.
// Assumes: Short time base of 4 cycles per ms.
// Notes:   Each phase is sampled every cycle; steady patterns and the last blink phase are sampled for only part of their length.
`timescale 1ns/10ps
module canopen_status_led_sequencer_tb_top;
   localparam int C = 4;
   localparam logic [1:0] RED = 2'h2;
   localparam logic [1:0] GRN = 2'h1;
   localparam logic [1:0] OFF = 2'h0;
   localparam logic [9:0] SL = 10'h200, RS = 10'h100, UC = 10'h080, BO = 10'h040;
   localparam logic [9:0] EV = 10'h020, WN = 10'h010, AB = 10'h008, OP = 10'h004;
   localparam logic [9:0] PR = 10'h002, HL = 10'h001;
   logic       clk;
   logic       rst;
   logic [9:0] cond;
   logic       led_red;
   logic       led_green;
   logic [2:0] shown_pattern;
   logic [1:0] colour;
   int         fail_count;
   int         comparisons;
   canopen_status_led_sequencer #(.CYCLES_PER_MS(C)) u_dut (
      .clk(clk), .rst(rst), .slave_role(cond[9]), .reset_active(cond[8]),
      .unconfigured(cond[7]), .bus_off(cond[6]), .error_control_event(cond[5]),
      .warning_reached(cond[4]), .autobaud_active(cond[3]), .operational(cond[2]),
      .preparing_state(cond[1]), .halted_state(cond[0]), .led_red(led_red),
      .led_green(led_green), .shown_pattern(shown_pattern));
   led_lamp u_lamp (.led_red(led_red), .led_green(led_green), .colour(colour));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic chk(input logic [2:0] seen, input logic [2:0] exp, input string what);
      comparisons++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD %0t %s", $time, what);
      end
   endtask
   task automatic go(input logic [9:0] c, input logic [2:0] pat);
      cond = c;
      @(posedge clk);
      #1;
      chk(shown_pattern, pat, "pattern");
      chk({1'b0, colour}, 3'h0, "restart dark");
      @(posedge clk);
      #1;
   endtask
   task automatic phase(input logic [1:0] col, input int ms);
      logic ok;
      ok = 1'b1;
      repeat (ms * C) begin
         if (colour !== col) ok = 1'b0;
         @(posedge clk);
         #1;
      end
      chk({2'h0, ok}, 3'h1, "phase colour or length");
   endtask
   task automatic close_out;
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // ---------------------------------------------------------------
   // Tests
   // ---------------------------------------------------------------
   initial begin
      rst = 1'b1;
      cond = 10'h0;
      fail_count = 0;
      comparisons = 0;
      repeat (2) @(posedge clk);
      #1;
      rst = 1'b0;
      chk(shown_pattern, 3'h0, "reset pattern");
      chk({1'b0, colour}, 3'h0, "reset dark");
      $display("test reset done");
      go(OP, led_seq_pkg::PAT_GREEN_ON);
      phase(GRN, 300);
      go(PR, led_seq_pkg::PAT_BLINK_G);
      phase(GRN, 200);
      phase(OFF, 200);
      phase(GRN, 100);
      $display("test steady and blink done");
      go(HL, led_seq_pkg::PAT_SFLASH_G);
      phase(GRN, 200);
      phase(OFF, 1000);
      phase(GRN, 200);
      go(WN | HL, led_seq_pkg::PAT_SFLASH_R);
      phase(RED, 200);
      phase(OFF, 1000);
      $display("test single flash done");
      go(EV | WN | HL, led_seq_pkg::PAT_DFLASH_R);
      phase(RED, 200);
      phase(OFF, 200);
      phase(RED, 200);
      phase(OFF, 1000);
      phase(RED, 200);
      go(BO | EV | OP, led_seq_pkg::PAT_RED_ON);
      phase(RED, 300);
      $display("test errors done");
      go(RS | BO, led_seq_pkg::PAT_DARK);
      phase(OFF, 100);
      go(UC | OP, led_seq_pkg::PAT_DARK);
      phase(OFF, 100);
      go(SL | AB | OP, led_seq_pkg::PAT_FLICKER);
      phase(RED, 50);
      phase(OFF, 50);
      phase(GRN, 50);
      phase(OFF, 50);
      phase(RED, 50);
      go(AB | OP, led_seq_pkg::PAT_GREEN_ON);
      phase(GRN, 100);
      go(SL, led_seq_pkg::PAT_DARK);
      phase(OFF, 100);
      $display("test dark and flicker done");
      go(OP, led_seq_pkg::PAT_GREEN_ON);
      phase(GRN, 50);
      rst = 1'b1;
      repeat (2) @(posedge clk);
      #1;
      chk(shown_pattern, 3'h0, "mid-run reset pattern");
      chk({1'b0, colour}, 3'h0, "mid-run reset dark");
      rst = 1'b0;
      go(OP, led_seq_pkg::PAT_GREEN_ON);
      phase(GRN, 100);
      $display("test mid-run reset done");
      close_out();
   end
   initial begin
      repeat (60000) @(posedge clk);
      fail_count++;
      $display("BAD %0t watchdog expired", $time);
      close_out();
   end
endmodule
bind canopen_status_led_sequencer led_seq_props #(.CYCLES_PER_MS(CYCLES_PER_MS)) u_props (
   .clk(clk), .rst(rst), .slave_role(slave_role), .reset_active(reset_active),
   .unconfigured(unconfigured), .bus_off(bus_off), .error_control_event(error_control_event),
   .warning_reached(warning_reached), .autobaud_active(autobaud_active),
   .operational(operational), .preparing_state(preparing_state), .halted_state(halted_state),
   .led_red(led_red), .led_green(led_green), .shown_pattern(shown_pattern));

/* verification/led_lamp.sv */
// Purpose: Behavioural bicolour indicator element.
// Assumes: Driven straight from the sequencer outputs.
// Notes:   Overlap is not masked, so both lit shows as 2'h3.
`timescale 1ns/10ps
module led_lamp (
   input  wire logic       led_red,   // Red part drive
   input  wire logic       led_green, // Green part drive
   output logic [1:0]      colour     // Seen colour, red then green
);
   assign colour = {led_red, led_green};
endmodule

/* verification/led_seq_props.sv */
// Purpose: Port assertions for the status indicator sequencer.
// Assumes: One clock domain; bound to the sequencer's top module.
// Notes:   Phase lengths are measured by lit and dark run counters.
`timescale 1ns/10ps
module led_seq_props #(
   parameter int CYCLES_PER_MS = 4
) (
   input wire logic       clk,                 // System clock
   input wire logic       rst,                 // Synchronous reset
   input wire logic       slave_role,          // Slave stack
   input wire logic       reset_active,        // Node in reset
   input wire logic       unconfigured,        // No configuration
   input wire logic       bus_off,             // Bus-off
   input wire logic       error_control_event, // Error-control event
   input wire logic       warning_reached,     // Warning level reached
   input wire logic       autobaud_active,     // Bit-rate detection
   input wire logic       operational,         // Running state
   input wire logic       preparing_state,     // Preparing state
   input wire logic       halted_state,        // Halted state
   input wire logic       led_red,             // Red element
   input wire logic       led_green,           // Green element
   input wire logic [2:0] shown_pattern        // Pattern on display
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // ---------------------------------------------------------------
   // Run counters
   // ---------------------------------------------------------------
   logic        lit;
   logic        flash;
   logic        idle;
   logic [15:0] on_cnt_ff;
   logic [15:0] off_cnt_ff;
   assign lit   = led_red | led_green;
   assign idle  = reset_active | unconfigured;
   assign flash = shown_pattern inside {led_seq_pkg::PAT_SFLASH_G, led_seq_pkg::PAT_SFLASH_R,
                                        led_seq_pkg::PAT_DFLASH_R};
   // Cleared on a pattern change so the forced dark restart cycle is never timed
   always_ff @(posedge clk) begin
      if (rst || $changed(shown_pattern)) begin
         on_cnt_ff  <= 16'h0;
         off_cnt_ff <= 16'h0;
      end else if (lit) begin
         on_cnt_ff  <= on_cnt_ff + 16'h1;
         off_cnt_ff <= 16'h0;
      end else begin
         off_cnt_ff <= off_cnt_ff + 16'h1;
         on_cnt_ff  <= 16'h0;
      end
   end
   // ---------------------------------------------------------------
   // Properties
   // ---------------------------------------------------------------
   property p_exit_rst;
      $fell(rst) |-> shown_pattern == 3'h0 && !lit;
   endproperty
   property p_idle;
      idle |=> shown_pattern == led_seq_pkg::PAT_DARK;
   endproperty
   property p_busoff;
      bus_off && !idle |=> shown_pattern == led_seq_pkg::PAT_RED_ON;
   endproperty
   property p_event;
      error_control_event && !bus_off && !idle |=> shown_pattern == led_seq_pkg::PAT_DFLASH_R;
   endproperty
   property p_warn;
      warning_reached && !error_control_event && !bus_off && !idle
         |=> shown_pattern == led_seq_pkg::PAT_SFLASH_R;
   endproperty
   property p_flicker_sel;
      slave_role && autobaud_active && !warning_reached && !error_control_event && !bus_off
         && !idle |=> shown_pattern == led_seq_pkg::PAT_FLICKER;
   endproperty
   property p_restart;
      $changed(shown_pattern) |-> !lit;
   endproperty
   property p_one_colour;
      !(led_red && led_green);
   endproperty
   property p_steady;
      $stable(shown_pattern) && shown_pattern inside {led_seq_pkg::PAT_RED_ON,
         led_seq_pkg::PAT_GREEN_ON} |-> led_red == (shown_pattern == led_seq_pkg::PAT_RED_ON)
         && led_green == (shown_pattern == led_seq_pkg::PAT_GREEN_ON);
   endproperty
   property p_short_on;
      $fell(lit) && $stable(shown_pattern) && (flash || shown_pattern == led_seq_pkg::PAT_BLINK_G)
         |-> on_cnt_ff == 16'(200 * CYCLES_PER_MS);
   endproperty
   property p_long_off;
      $rose(lit) && off_cnt_ff != 16'h0 && flash |-> off_cnt_ff == 16'(1000 * CYCLES_PER_MS)
         || (shown_pattern == led_seq_pkg::PAT_DFLASH_R && off_cnt_ff == 16'(200 * CYCLES_PER_MS));
   endproperty
   property p_flicker_on;
      $fell(lit) && $stable(shown_pattern) && shown_pattern == led_seq_pkg::PAT_FLICKER
         |-> on_cnt_ff == 16'(50 * CYCLES_PER_MS);
   endproperty
   a_exit_rst:    assert property (p_exit_rst) else $error("not dark after reset");
   a_idle:        assert property (p_idle) else $error("idle not dark");
   a_busoff:      assert property (p_busoff) else $error("bus-off not red on");
   a_event:       assert property (p_event) else $error("event not double flash");
   a_warn:        assert property (p_warn) else $error("warning not red flash");
   a_flicker_sel: assert property (p_flicker_sel) else $error("no flicker");
   a_restart:     assert property (p_restart) else $error("lit on change");
   a_one_colour:  assert property (p_one_colour) else $error("both lit");
   a_steady:      assert property (p_steady) else $error("steady colour wrong");
   a_short_on:    assert property (p_short_on) else $error("on phase length");
   a_long_off:    assert property (p_long_off) else $error("off phase length");
   a_flicker_on:  assert property (p_flicker_on) else $error("flicker length");
   c_flicker: cover property ($fell(lit) && shown_pattern == led_seq_pkg::PAT_FLICKER);
   c_dflash:  cover property ($rose(lit) && shown_pattern == led_seq_pkg::PAT_DFLASH_R);
   c_busoff:  cover property (led_red && shown_pattern == led_seq_pkg::PAT_RED_ON);
endmodule
